// >>> aof_pkg.sv
`default_nettype none
package aof_pkg;
   localparam int DATA_W = 10;
   localparam int HALF_W = DATA_W / 2;
   localparam int NUM_CORES = 2;
   localparam int CNT_W = 17;
   localparam int CLK_MHZ = 125;
   localparam int NAP_WAKE_NS = 1000;
   localparam int NAP_WAKE_CYC = (NAP_WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam int SLEEP_WAKE_US = 1000;
   localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_US * CLK_MHZ;
   localparam int DLL_RELOCK_US = 52;
   localparam int DLL_RELOCK_CYC = DLL_RELOCK_US * CLK_MHZ;
   localparam int CS_SETUP_US = 150;
   localparam int CS_SETUP_CYC = CS_SETUP_US * CLK_MHZ;
   localparam int CLK_STOP_NS = 2000;
   localparam int CLK_STOP_CYC = (CLK_STOP_NS * CLK_MHZ) / 1000;
   localparam int STRAP_SETTLE_CYC = 4;
   localparam int DDR_PHASE_CYC = 2;
   localparam int BUF_DEPTH = 2;
   // synchroniser bit positions
   localparam int IX_CS = 0;
   localparam int IX_CONV = 1;
   localparam int IX_OM = 2;
   localparam int IX_PS = 4;
   localparam int IX_CF = 6;
   localparam int SYN_W = 8;
   localparam logic [SYN_W-1:0] SYN_RST = 8'h01;
   typedef enum logic [1:0] {
      LVL_LOW = 2'b00, LVL_FLOAT = 2'b01, LVL_HIGH = 2'b10
   } aof_lvl_t;
   typedef enum logic [1:0] {
      FMT_OBIN = 2'b00, FMT_TWOS = 2'b01, FMT_GRAY = 2'b10
   } aof_fmt_t;
   typedef enum logic [1:0] {
      OM_CMOS = 2'b00, OM_LVDS3 = 2'b01, OM_LVDS2 = 2'b10
   } aof_omode_t;
   typedef enum logic [1:0] {
      PM_NORMAL = 2'b00, PM_SLEEP = 2'b01, PM_NAP = 2'b10
   } aof_pmode_t;
   typedef enum logic [1:0] {
      PS_RUN = 2'b00, PS_NAP = 2'b01, PS_SLEEP = 2'b10, PS_WAKE = 2'b11
   } aof_pstate_t;
   typedef enum logic [1:0] {
      SR_IDLE = 2'b00, SR_HI = 2'b01, SR_LO = 2'b10
   } aof_ser_t;
   // an unused strap code of 11 is read as floating
   function automatic aof_lvl_t lvl_fix(input logic [1:0] v);
      lvl_fix = (v == 2'b11) ? LVL_FLOAT : aof_lvl_t'(v);
   endfunction
endpackage
`default_nettype wire

// >>> aof_smp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aof_smp_if #(parameter int W = 10);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   logic ovr;
   modport src (output valid, output data, output ovr, input ready);
   modport snk (input valid, input data, input ovr, output ready);
endinterface
`default_nettype wire

// >>> aof_fmt.sv
`timescale 1ns/1ps
`default_nettype none
module aof_fmt #(parameter int W = aof_pkg::DATA_W) (
   input wire logic clk_in, // core clock
   input wire logic rst_n_in, // async reset, low
   input wire logic take_in, // one pulse per sample
   input wire logic [W-1:0] raw_in, // offset binary sample
   input wire logic raw_ovr_in, // input above full scale
   input wire aof_pkg::aof_fmt_t fmt_in, // selected coding
   aof_smp_if.src smp // formatted word out
);
   import aof_pkg::*;
   logic vld_ff, nxt_vld, ovr_ff, nxt_ovr;
   logic [W-1:0] dat_ff, nxt_dat, sat;

   function automatic logic [W-1:0] code_of(input logic [W-1:0] b, input aof_fmt_t f);
      unique case (f)
         FMT_OBIN: code_of = b;
         FMT_TWOS: code_of = {~b[W-1], b[W-2:0]};
         FMT_GRAY: code_of = b ^ (b >> 1);
         default: code_of = b;
      endcase
   endfunction

   always_comb begin
      sat = raw_ovr_in ? {W{1'b1}} : raw_in;
      nxt_vld = vld_ff;
      nxt_dat = dat_ff;
      nxt_ovr = ovr_ff;
      if (vld_ff && smp.ready) begin
         nxt_vld = 1'b0;
      end
      // a word that finds the held word still waiting on a full buffer is dropped; ready is exported
      if (take_in && (!vld_ff || smp.ready)) begin
         nxt_vld = 1'b1;
         nxt_dat = code_of(sat, fmt_in);
         nxt_ovr = raw_ovr_in | (&raw_in);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         vld_ff <= 1'b0;
         dat_ff <= '0;
         ovr_ff <= 1'b0;
      end else begin
         vld_ff <= nxt_vld;
         dat_ff <= nxt_dat;
         ovr_ff <= nxt_ovr;
      end
   end

   assign smp.valid = vld_ff;
   assign smp.data = dat_ff;
   assign smp.ovr = ovr_ff;
endmodule // aof_fmt
`default_nettype wire

// >>> aof_buf.sv
`timescale 1ns/1ps
`default_nettype none
module aof_buf #(
   parameter int W = aof_pkg::DATA_W,
   parameter int DEPTH = aof_pkg::BUF_DEPTH
) (
   input wire logic clk_in, // core clock
   input wire logic rst_n_in, // async reset, low
   aof_smp_if.snk smp, // filling side
   output logic out_valid_out, // word available
   input wire logic out_ready_in, // drain side takes word
   output logic [W-1:0] out_data_out, // head word
   output logic out_ovr_out // head over-range flag
);
   import aof_pkg::*;
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [W:0] mem_ff [DEPTH];
   logic [W:0] nxt_mem [DEPTH];
   logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic push, pop;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign smp.ready = (cnt_ff != CW'(DEPTH));
   assign out_valid_out = (cnt_ff != '0);
   assign push = smp.valid && smp.ready;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem_ff[rp_ff][W-1:0];
   assign out_ovr_out = mem_ff[rp_ff][W];

   always_comb begin
      nxt_mem = mem_ff;
      nxt_wp = push ? inc(wp_ff) : wp_ff;
      nxt_rp = pop ? inc(rp_ff) : rp_ff;
      nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
      if (push) begin
         nxt_mem[wp_ff] = {smp.ovr, smp.data};
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         mem_ff <= nxt_mem;
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule // aof_buf
`default_nettype wire

// >>> aof_top.sv
// Overview of operation
// - samples leave on a parallel DDR bus in both LVDS and CMOS modes
// - output strap low CMOS, floating LVDS 3mA, high LVDS 2mA
// - a serial output mode setting overrides the output strap
// - over-range flag rises when the sample reaches positive full scale
// - over-range saturates the code at full scale, never wraps
// - over-range flag is updated once per sample
// - leaving nap returns to conversion in about 1us
// - leaving sleep takes about 1ms after the wake command
// - chip select low through sleep keeps settings alive, no 150us wait
// - data, output clock and flag float during nap or sleep
// - nap recovery stretches to DLL relock, up to 52us, if clock stopped
// - power strap after reset: low normal, floating sleep, high nap
// - serial power setting overrides strap, per selected core only
// - format strap low offset binary, floating twos complement, high Gray
// - a serial format setting overrides the format strap
// - offset binary spans zeros to ones; twos complement flips the top bit
// - Gray keeps the top bit, lower bits xor with the next bit up
`timescale 1ns/1ps
`default_nettype none
module aof_top #(
   parameter int NC = aof_pkg::NUM_CORES,
   parameter int P_SLEEP_WAKE = aof_pkg::SLEEP_WAKE_CYC,
   parameter int P_DLL_RELOCK = aof_pkg::DLL_RELOCK_CYC,
   parameter int P_CS_SETUP = aof_pkg::CS_SETUP_CYC
) (
   input wire logic ref_clk_in, // core clock 125 MHz
   input wire logic rst_n_in, // async reset, low
   input wire logic conv_clk_in, // conversion clock pin
   input wire logic [aof_pkg::DATA_W-1:0] raw_sample_in, // core sample
   input wire logic raw_ovr_in, // core above full scale
   input wire logic [1:0] output_drive_strap_in, // 3-level strap
   input wire logic [1:0] power_state_strap_in, // 3-level strap
   input wire logic [1:0] code_format_strap_in, // 3-level strap
   input wire logic chip_select_n_in, // serial select pin
   input wire logic spi_omode_wr_in, // output mode write
   input wire aof_pkg::aof_omode_t spi_omode_in, // output mode value
   input wire logic spi_fmt_wr_in, // format write
   input wire aof_pkg::aof_fmt_t spi_fmt_in, // format value
   input wire logic spi_pwr_wr_in, // power mode write
   input wire aof_pkg::aof_pmode_t spi_pwr_in, // power mode value
   input wire logic [NC-1:0] core_sel_in, // indexed core select
   input wire logic rx_ready_in, // receiver accepts words
   output logic [aof_pkg::HALF_W-1:0] ddr_data_out, // DDR data
   output logic ddr_data_oe_out, // data driven
   output logic output_clock_out, // DDR clock
   output logic output_clock_oe_out, // clock driven
   output logic ovr_flag_out, // over-range flag
   output logic ovr_flag_oe_out, // flag driven
   output logic lvds_mode_out, // 1 LVDS, 0 CMOS
   output logic lvds_low_drive_out, // 2mA drive
   output logic [NC-1:0] core_run_out, // core converting
   output logic spi_regs_ready_out, // settings accepted
   output logic smp_ready_out // buffer has room
);
   import aof_pkg::*;

   // pin synchronisers
   logic [SYN_W-1:0] pin_vec, sy1_ff, sy2_ff, sy3_ff, flt_ff, nxt_flt;
   logic conv_prev_ff, conv_rise, cs_n;

   assign pin_vec = {code_format_strap_in, power_state_strap_in,
                     output_drive_strap_in, conv_clk_in, chip_select_n_in};

   always_comb begin
      for (int i = 0; i < SYN_W; i++) begin
         nxt_flt[i] = (sy2_ff[i] == sy3_ff[i]) ? sy3_ff[i] : flt_ff[i];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sy1_ff <= SYN_RST;
         sy2_ff <= SYN_RST;
         sy3_ff <= SYN_RST;
         flt_ff <= SYN_RST;
         conv_prev_ff <= 1'b0;
      end else begin
         sy1_ff <= pin_vec;
         sy2_ff <= sy1_ff;
         sy3_ff <= sy2_ff;
         flt_ff <= nxt_flt;
         conv_prev_ff <= flt_ff[IX_CONV];
      end
   end

   assign conv_rise = flt_ff[IX_CONV] & ~conv_prev_ff;
   assign cs_n = flt_ff[IX_CS];

   // strap capture, once after reset release
   logic [2:0] st_cnt_ff, nxt_st_cnt;
   logic st_done_ff, nxt_st_done;
   aof_lvl_t om_lat_ff, nxt_om_lat, ps_lat_ff, nxt_ps_lat, cf_lat_ff, nxt_cf_lat;

   always_comb begin
      nxt_st_cnt = st_cnt_ff;
      nxt_st_done = st_done_ff;
      nxt_om_lat = om_lat_ff;
      nxt_ps_lat = ps_lat_ff;
      nxt_cf_lat = cf_lat_ff;
      if (!st_done_ff) begin
         nxt_st_cnt = st_cnt_ff + 3'h1;
         // filter output only holds the pins from the fourth count on, so capture waits one edge more
         if (st_cnt_ff == 3'(STRAP_SETTLE_CYC)) begin
            nxt_st_done = 1'b1;
            nxt_om_lat = lvl_fix(flt_ff[IX_OM +: 2]);
            nxt_ps_lat = lvl_fix(flt_ff[IX_PS +: 2]);
            nxt_cf_lat = lvl_fix(flt_ff[IX_CF +: 2]);
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_cnt_ff <= '0;
         st_done_ff <= 1'b0;
         om_lat_ff <= LVL_LOW;
         ps_lat_ff <= LVL_LOW;
         cf_lat_ff <= LVL_LOW;
      end else begin
         st_cnt_ff <= nxt_st_cnt;
         st_done_ff <= nxt_st_done;
         om_lat_ff <= nxt_om_lat;
         ps_lat_ff <= nxt_ps_lat;
         cf_lat_ff <= nxt_cf_lat;
      end
   end

   // serial overrides; ignored while the settings are unpowered
   logic regs_ok_ff, nxt_regs_ok;
   logic [CNT_W-1:0] cs_cnt_ff, nxt_cs_cnt;
   logic om_ovr_ff, nxt_om_ovr, cf_ovr_ff, nxt_cf_ovr;
   aof_omode_t om_spi_ff, nxt_om_spi, eff_om;
   aof_fmt_t cf_spi_ff, nxt_cf_spi, eff_cf;
   logic [NC-1:0] pw_ovr_ff, nxt_pw_ovr;
   aof_pmode_t pw_spi_ff [NC];
   aof_pmode_t nxt_pw_spi [NC];
   aof_pmode_t tgt [NC];

   always_comb begin
      nxt_om_ovr = om_ovr_ff;
      nxt_om_spi = om_spi_ff;
      nxt_cf_ovr = cf_ovr_ff;
      nxt_cf_spi = cf_spi_ff;
      nxt_pw_ovr = pw_ovr_ff;
      nxt_pw_spi = pw_spi_ff;
      if (regs_ok_ff && spi_omode_wr_in) begin
         nxt_om_ovr = 1'b1;
         nxt_om_spi = spi_omode_in;
      end
      if (regs_ok_ff && spi_fmt_wr_in) begin
         nxt_cf_ovr = 1'b1;
         nxt_cf_spi = spi_fmt_in;
      end
      for (int c = 0; c < NC; c++) begin
         if (regs_ok_ff && spi_pwr_wr_in && core_sel_in[c]) begin
            nxt_pw_ovr[c] = 1'b1;
            nxt_pw_spi[c] = spi_pwr_in;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         om_ovr_ff <= 1'b0;
         om_spi_ff <= OM_CMOS;
         cf_ovr_ff <= 1'b0;
         cf_spi_ff <= FMT_OBIN;
         pw_ovr_ff <= '0;
         for (int c = 0; c < NC; c++) begin
            pw_spi_ff[c] <= PM_NORMAL;
         end
      end else begin
         om_ovr_ff <= nxt_om_ovr;
         om_spi_ff <= nxt_om_spi;
         cf_ovr_ff <= nxt_cf_ovr;
         cf_spi_ff <= nxt_cf_spi;
         pw_ovr_ff <= nxt_pw_ovr;
         pw_spi_ff <= nxt_pw_spi;
      end
   end

   assign eff_om = om_ovr_ff ? om_spi_ff : aof_omode_t'(om_lat_ff);
   assign eff_cf = cf_ovr_ff ? cf_spi_ff : aof_fmt_t'(cf_lat_ff);

   always_comb begin
      for (int c = 0; c < NC; c++) begin
         // the strap acts on every core alike
         tgt[c] = pw_ovr_ff[c] ? pw_spi_ff[c] : aof_pmode_t'(ps_lat_ff);
      end
   end

   // conversion clock watchdog for DLL relock
   logic [CNT_W-1:0] stop_cnt_ff, nxt_stop_cnt;
   logic lost_ff, nxt_lost, clk_stop, any_nap, all_run, all_sleep;
   aof_pstate_t pst_ff [NC];
   aof_pstate_t nxt_pst [NC];
   logic [CNT_W-1:0] wcnt_ff [NC];
   logic [CNT_W-1:0] nxt_wcnt [NC];

   assign clk_stop = (stop_cnt_ff == CNT_W'(CLK_STOP_CYC));

   always_comb begin
      any_nap = 1'b0;
      all_run = st_done_ff;
      all_sleep = 1'b1;
      for (int c = 0; c < NC; c++) begin
         any_nap = any_nap | (pst_ff[c] == PS_NAP);
         all_run = all_run & (pst_ff[c] == PS_RUN);
         all_sleep = all_sleep & (pst_ff[c] == PS_SLEEP);
      end
      nxt_stop_cnt = stop_cnt_ff;
      if (conv_rise) begin
         nxt_stop_cnt = '0;
      end else if (!clk_stop) begin
         nxt_stop_cnt = stop_cnt_ff + 1'b1;
      end
      // set wins over clear
      nxt_lost = lost_ff;
      if (all_run) begin
         nxt_lost = 1'b0;
      end
      if (any_nap && clk_stop) begin
         nxt_lost = 1'b1;
      end
   end

   // per-core power state machines
   always_comb begin
      for (int c = 0; c < NC; c++) begin
         nxt_pst[c] = pst_ff[c];
         nxt_wcnt[c] = wcnt_ff[c];
         if (st_done_ff) begin
            unique case (pst_ff[c])
               PS_RUN: begin
                  if (tgt[c] == PM_NAP) nxt_pst[c] = PS_NAP;
                  if (tgt[c] == PM_SLEEP) nxt_pst[c] = PS_SLEEP;
               end
               PS_NAP: begin
                  if (tgt[c] == PM_SLEEP) begin
                     nxt_pst[c] = PS_SLEEP;
                  end else if (tgt[c] == PM_NORMAL) begin
                     nxt_pst[c] = PS_WAKE;
                     nxt_wcnt[c] = (lost_ff || clk_stop) ? CNT_W'(P_DLL_RELOCK)
                                                         : CNT_W'(NAP_WAKE_CYC);
                  end
               end
               PS_SLEEP: begin
                  if (tgt[c] == PM_NAP) begin
                     nxt_pst[c] = PS_NAP;
                  end else if (tgt[c] == PM_NORMAL) begin
                     nxt_pst[c] = PS_WAKE;
                     nxt_wcnt[c] = CNT_W'(P_SLEEP_WAKE);
                  end
               end
               PS_WAKE: begin
                  if (tgt[c] == PM_NAP) begin
                     nxt_pst[c] = PS_NAP;
                  end else if (tgt[c] == PM_SLEEP) begin
                     nxt_pst[c] = PS_SLEEP;
                  end else if (wcnt_ff[c] <= CNT_W'(1)) begin
                     nxt_pst[c] = PS_RUN;
                  end else begin
                     nxt_wcnt[c] = wcnt_ff[c] - 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // settings lose power in full sleep with select high
   always_comb begin
      nxt_regs_ok = regs_ok_ff;
      nxt_cs_cnt = cs_cnt_ff;
      if (all_sleep && cs_n) begin
         nxt_regs_ok = 1'b0;
         nxt_cs_cnt = '0;
      end else if (!regs_ok_ff) begin
         if (!all_sleep || cs_cnt_ff == CNT_W'(P_CS_SETUP - 1)) begin
            nxt_regs_ok = 1'b1;
         end else begin
            nxt_cs_cnt = cs_cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stop_cnt_ff <= '0;
         lost_ff <= 1'b0;
         regs_ok_ff <= 1'b1;
         cs_cnt_ff <= '0;
         for (int c = 0; c < NC; c++) begin
            pst_ff[c] <= PS_NAP;
            wcnt_ff[c] <= '0;
         end
      end else begin
         stop_cnt_ff <= nxt_stop_cnt;
         lost_ff <= nxt_lost;
         regs_ok_ff <= nxt_regs_ok;
         cs_cnt_ff <= nxt_cs_cnt;
         pst_ff <= nxt_pst;
         wcnt_ff <= nxt_wcnt;
      end
   end

   // sample path: format, then a two-word buffer
   aof_smp_if #(.W(DATA_W)) smp_bus ();
   logic buf_vld, buf_rdy, buf_ovr;
   logic [DATA_W-1:0] buf_dat;

   aof_fmt #(.W(DATA_W)) u_fmt (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .take_in(conv_rise && all_run),
      .raw_in(raw_sample_in),
      .raw_ovr_in(raw_ovr_in),
      .fmt_in(eff_cf),
      .smp(smp_bus)
   );

   aof_buf #(.W(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .smp(smp_bus),
      .out_valid_out(buf_vld),
      .out_ready_in(buf_rdy),
      .out_data_out(buf_dat),
      .out_ovr_out(buf_ovr)
   );

   // DDR serialiser: upper half with clock high, lower half with clock low
   aof_ser_t ser_ff, nxt_ser;
   logic [1:0] ph_ff, nxt_ph;
   logic [HALF_W-1:0] lo_ff, nxt_lo, ddr_ff, nxt_ddr;
   logic oclk_ff, nxt_oclk, flag_ff, nxt_flag, ph_last;

   assign ph_last = (ph_ff == 2'(DDR_PHASE_CYC - 1));
   assign buf_rdy = rx_ready_in && (ser_ff == SR_IDLE || (ser_ff == SR_LO && ph_last));

   always_comb begin
      nxt_ser = ser_ff;
      nxt_ph = ph_last ? 2'h0 : ph_ff + 2'h1;
      nxt_lo = lo_ff;
      nxt_ddr = ddr_ff;
      nxt_oclk = oclk_ff;
      nxt_flag = flag_ff;
      unique case (ser_ff)
         SR_IDLE: nxt_ph = 2'h0;
         SR_HI: begin
            if (ph_last) begin
               nxt_ser = SR_LO;
               nxt_ddr = lo_ff;
               nxt_oclk = 1'b0;
            end
         end
         SR_LO: begin
            if (ph_last) nxt_ser = SR_IDLE;
         end
         default: nxt_ser = SR_IDLE;
      endcase
      if (buf_vld && buf_rdy) begin
         nxt_ser = SR_HI;
         nxt_ph = 2'h0;
         nxt_ddr = buf_dat[DATA_W-1:HALF_W];
         nxt_lo = buf_dat[HALF_W-1:0];
         nxt_oclk = 1'b1;
         nxt_flag = buf_ovr;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ser_ff <= SR_IDLE;
         ph_ff <= '0;
         lo_ff <= '0;
         ddr_ff <= '0;
         oclk_ff <= 1'b0;
         flag_ff <= 1'b0;
      end else begin
         ser_ff <= nxt_ser;
         ph_ff <= nxt_ph;
         lo_ff <= nxt_lo;
         ddr_ff <= nxt_ddr;
         oclk_ff <= nxt_oclk;
         flag_ff <= nxt_flag;
      end
   end

   assign ddr_data_out = ddr_ff;
   assign output_clock_out = oclk_ff;
   assign ovr_flag_out = flag_ff;
   assign ddr_data_oe_out = all_run;
   assign output_clock_oe_out = all_run;
   assign ovr_flag_oe_out = all_run;
   assign lvds_mode_out = (eff_om != OM_CMOS);
   assign lvds_low_drive_out = (eff_om == OM_LVDS2);
   assign spi_regs_ready_out = regs_ok_ff;
   assign smp_ready_out = smp_bus.ready;

   always_comb begin
      for (int c = 0; c < NC; c++) begin
         core_run_out[c] = (pst_ff[c] == PS_RUN);
      end
   end
endmodule // aof_top
`default_nettype wire

// >>> aof_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module aof_top_properties #(parameter int NC = 2) (
   input wire logic ref_clk_in, // clock
   input wire logic rst_n_in, // reset
   input wire logic spi_omode_wr_in, // mode wr
   input wire aof_pkg::aof_omode_t spi_omode_in, // mode
   input wire logic spi_pwr_wr_in, // power wr
   input wire aof_pkg::aof_pmode_t spi_pwr_in, // power
   input wire logic [NC-1:0] core_sel_in, // cores
   input wire logic [aof_pkg::HALF_W-1:0] ddr_data_out, // data
   input wire logic ddr_data_oe_out, // data oe
   input wire logic output_clock_out, // ddr clock
   input wire logic ovr_flag_out, // flag
   input wire logic ovr_flag_oe_out, // flag oe
   input wire logic lvds_mode_out, // lvds
   input wire logic lvds_low_drive_out, // 2mA
   input wire logic [NC-1:0] core_run_out, // running
   input wire logic spi_regs_ready_out // regs on
);
   import aof_pkg::*;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   a_float_down: assert property (ddr_data_oe_out == &core_run_out)
      else $error("bus driven, core down");
   a_drive_lvds: assert property (lvds_low_drive_out |-> lvds_mode_out)
      else $error("2mA without lvds");
   a_omode_write: assert property (spi_omode_wr_in && spi_regs_ready_out |=>
      {lvds_mode_out, lvds_low_drive_out} == {$past(spi_omode_in) != OM_CMOS,
      $past(spi_omode_in) == OM_LVDS2}) else $error("mode write lost");
   a_ddr_high: assert property ($rose(output_clock_out) |=>
      output_clock_out && $stable(ddr_data_out)) else $error("upper half short");
   // a power-down may cut the lower half, so only a driven bus must hold it
   a_ddr_low: assert property ($fell(output_clock_out) |=>
      $stable(ddr_data_out) || !ddr_data_oe_out) else $error("lower half short");
   a_flag_slot: assert property ($changed(ovr_flag_out) && $stable(ovr_flag_oe_out)
      && ovr_flag_oe_out |-> $rose(output_clock_out)) else $error("flag off slot");
   a_pwr_down: assert property (spi_pwr_wr_in && spi_regs_ready_out && |core_sel_in
      && spi_pwr_in != PM_NORMAL |-> ##[1:2] !ddr_data_oe_out) else $error("still driven");
   a_regs_sleep: assert property ($fell(spi_regs_ready_out) |-> core_run_out == '0)
      else $error("regs off while awake");
   c_flag: cover property ($rose(ovr_flag_out));
   c_wake: cover property ($rose(ddr_data_oe_out));
   c_regs_off: cover property ($fell(spi_regs_ready_out));
endmodule // aof_top_properties
bind aof_top aof_top_properties #(.NC(NC)) u_aof_top_properties (.*);
`default_nettype wire

// >>> aof_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module aof_rx_model #(parameter int W = 5) (
   input wire logic clk_in, // core clock
   input wire logic [W-1:0] ddr_in, // ddr data
   input wire logic dclk_in, // output clock
   input wire logic oe_in, // bus driven
   input wire logic flag_in, // over-range
   input wire logic stall_in, // hold off
   output logic ready_out, // accepts words
   output logic [2*W-1:0] word_out, // last word
   output logic flag_out, // its flag
   output int count_out // words taken
);
   logic dclk_q = 1'b0;
   logic [W-1:0] upper = '0;
   assign ready_out = !stall_in;
   initial count_out = 0;
   // a floating bus is never sampled, its level means nothing
   always @(posedge clk_in) begin
      dclk_q <= dclk_in;
      if (oe_in && dclk_in && !dclk_q) begin
         upper <= ddr_in;
         flag_out <= flag_in;
      end
      if (oe_in && !dclk_in && dclk_q) begin
         word_out <= {upper, ddr_in};
         count_out <= count_out + 1;
      end
   end
endmodule // aof_rx_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
   import aof_pkg::*;
   typedef struct packed {logic wr; aof_fmt_t f; logic [9:0] raw; logic ovr, fl; logic [9:0] exp;} aof_row_t;
   localparam int SLP = 200;
   localparam int RLK = 300;
   localparam int CSS = 50;
   logic ref_clk_in = 1'b0, rst_n_in = 1'b0, conv_clk_in = 1'b0, conv_en = 1'b1, raw_ovr_in = 1'b0;
   logic [9:0] raw_sample_in = '0;
   logic [1:0] output_drive_strap_in = 2'h1, power_state_strap_in = 2'h0;
   logic [1:0] code_format_strap_in = 2'h1, core_sel_in = 2'h3;
   logic chip_select_n_in = 1'b1;
   logic spi_omode_wr_in = 1'b0, spi_fmt_wr_in = 1'b0, spi_pwr_wr_in = 1'b0, stall = 1'b0;
   aof_omode_t spi_omode_in = OM_CMOS;
   aof_fmt_t spi_fmt_in = FMT_OBIN;
   aof_pmode_t spi_pwr_in = PM_NORMAL;
   logic rx_ready_in, ddr_data_oe_out, output_clock_out, output_clock_oe_out, ovr_flag_out;
   logic ovr_flag_oe_out, lvds_mode_out, lvds_low_drive_out, spi_regs_ready_out, smp_ready_out;
   logic rx_flag;
   logic [4:0] ddr_data_out;
   logic [1:0] core_run_out;
   logic [9:0] rx_word;
   int rx_count, errors = 0, n_tests = 0;
   aof_row_t rows [9] = '{'{0, FMT_TWOS, 10'h000, 0, 0, 10'h200},
      '{1, FMT_OBIN, 10'h3FE, 0, 0, 10'h3FE}, '{1, FMT_TWOS, 10'h3FE, 0, 0, 10'h1FE},
      '{1, FMT_GRAY, 10'h200, 0, 0, 10'h300}, '{1, FMT_GRAY, 10'h3FE, 0, 0, 10'h201},
      '{1, FMT_OBIN, 10'h3FF, 0, 1, 10'h3FF}, '{1, FMT_TWOS, 10'h155, 1, 1, 10'h1FF},
      '{1, FMT_GRAY, 10'h001, 1, 1, 10'h200}, '{1, FMT_OBIN, 10'h001, 0, 0, 10'h001}};
   aof_top #(.P_SLEEP_WAKE(SLP), .P_DLL_RELOCK(RLK), .P_CS_SETUP(CSS)) u_aof_top (.*);
   aof_rx_model u_aof_rx_model (.clk_in(ref_clk_in), .ddr_in(ddr_data_out),
      .dclk_in(output_clock_out), .oe_in(ddr_data_oe_out), .flag_in(ovr_flag_out),
      .stall_in(stall), .ready_out(rx_ready_in), .word_out(rx_word), .flag_out(rx_flag),
      .count_out(rx_count));
   always #4 ref_clk_in = ~ref_clk_in;
   // stopped only where a test wants the relock path
   always #62.5 conv_clk_in = conv_en & ~conv_clk_in;
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   // the extra cycle keeps back to back pulses apart
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
      step(1);
   endtask
   task automatic words(input int n);
      int c;
      c = rx_count + n;
      repeat (400) if (rx_count < c) step(1);
      `CHK(rx_count >= c, 1'b1)
   endtask
   task automatic cycle_pwr(input aof_pmode_t m, input int t, input logic stop);
      spi_pwr_in = m;
      pulse(spi_pwr_wr_in);
      conv_en = !stop;
      step(300);
      conv_en = 1'b1;
      if (m == PM_SLEEP) begin
         `CHK(spi_regs_ready_out, ~chip_select_n_in)
         chip_select_n_in = 1'b0;
         step(CSS + 10);
         `CHK(spi_regs_ready_out, 1'b1)
      end
      spi_pwr_in = PM_NORMAL;
      pulse(spi_pwr_wr_in);
      step(t - 10);
      `CHK(core_run_out, 2'h0)
      step(20);
      `CHK(core_run_out, 2'h3)
      chip_select_n_in = 1'b1;
   endtask
   task automatic close_out;
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      step(2);
      rst_n_in = 1'b1;
      step(200);
      `CHK({core_run_out, lvds_mode_out, lvds_low_drive_out}, 4'hE)
      for (int i = 0; i < 3; i++) begin
         spi_omode_in = aof_omode_t'(i);
         pulse(spi_omode_wr_in);
         `CHK({lvds_mode_out, lvds_low_drive_out}, {i != 0, i == 2})
      end
      foreach (rows[i]) begin
         spi_fmt_in = rows[i].f;
         if (rows[i].wr) pulse(spi_fmt_wr_in);
         raw_sample_in = rows[i].raw;
         raw_ovr_in = rows[i].ovr;
         words(3);
         `CHK({rx_flag, rx_word}, {rows[i].fl, rows[i].exp})
      end
      stall = 1'b1;
      step(100);
      `CHK(smp_ready_out, 1'b0)
      stall = 1'b0;
      words(3);
      `CHK({smp_ready_out, rx_word}, {1'b1, 10'h001})
      core_sel_in = 2'h2;
      spi_pwr_in = PM_NAP;
      pulse(spi_pwr_wr_in);
      `CHK({core_run_out, ddr_data_oe_out, output_clock_oe_out, ovr_flag_oe_out}, 5'h08)
      core_sel_in = 2'h3;
      cycle_pwr(PM_NAP, NAP_WAKE_CYC, 1'b0);
      cycle_pwr(PM_NAP, RLK, 1'b1);
      cycle_pwr(PM_SLEEP, SLP, 1'b0);
      chip_select_n_in = 1'b0;
      step(4);
      cycle_pwr(PM_SLEEP, SLP, 1'b0);
      power_state_strap_in = 2'h2;
      rst_n_in = 1'b0;
      step(2);
      rst_n_in = 1'b1;
      step(200);
      `CHK({core_run_out, ddr_data_oe_out}, 3'h0)
      close_out;
   end
   initial begin
      #60000;
      errors++;
      close_out;
   end
endmodule // testbench
`default_nettype wire
